//--- logic/gpm_pkg.sv
// Purpose: shared constants and types for the gauge power and measurement block
// Assumes: 25 MHz reference clock
// Notes:   analog converters sit outside; results arrive as raw codes
`default_nettype none
package gpm_pkg;
  localparam int unsigned CLK_HZ            = 25_000_000;
  localparam int unsigned SLEEP_DELAY_MS    = 2000;
  localparam int unsigned SLEEP_DELAY_CYC   = SLEEP_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned VT_PERIOD_MS      = 440;
  localparam int unsigned VT_PERIOD_CYC     = VT_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned CONV_PERIOD_US    = 3_515_000;
  localparam int unsigned CONV_PERIOD_CYC   = (CONV_PERIOD_US / 1000) * (CLK_HZ / 1000);
  localparam int unsigned SAMPLE_HZ         = 18_600;
  localparam int unsigned SAMPLE_CYC        = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned AVG_DEPTH         = 8;
  localparam int unsigned AVG_LOG2          = 3;
  localparam int unsigned OFFSET_SLOT_EVERY = 1024;
  localparam int unsigned GAIN_W            = 11;
  localparam int unsigned GAIN_FRAC         = 10;
  localparam int unsigned TEMPCO_W          = 8;
  localparam int unsigned TEMP_HALF_SHIFT   = 2;
  localparam int unsigned TEMPCO_SHIFT      = 16;
  localparam int unsigned RES_W             = 16;
  localparam logic signed [RES_W-1:0] RES_MAX = 16'sh7FFF;
  localparam logic signed [RES_W-1:0] RES_MIN = 16'sh8000;
  localparam logic [RES_W-1:0]        RES_RST = 16'h0000;

  typedef enum logic [1:0] {
    GPM_ACTIVE    = 2'b00,
    GPM_SLEEP_BUS = 2'b01,
    GPM_SLEEP_UV  = 2'b10
  } gpm_mode_t;

  typedef struct packed {
    logic signed [RES_W-1:0] voltage;
    logic signed [RES_W-1:0] temperature;
    logic signed [RES_W-1:0] current;
    logic signed [RES_W-1:0] avg_current;
  } gpm_results_t;

  typedef struct packed {
    logic [GAIN_W-1:0]   gain_trim;
    logic [GAIN_W-1:0]   factory_gain;
    logic [TEMPCO_W-1:0] tempco;
  } gpm_trim_t;
endpackage
`default_nettype wire

//--- logic/gpm_sat.sv
// Purpose: clamp a wide signed value onto a result code
// Assumes: input wider than output
// Notes:   combinational only
`default_nettype none
module gpm_sat #(
  parameter int unsigned IN_W  = 40,
  parameter int unsigned OUT_W = 16
) (
  // value
  input  wire logic signed [IN_W-1:0]  val_i,
  // clamped
  output logic signed [OUT_W-1:0] sat_o
);
  localparam logic signed [IN_W-1:0] HI = (IN_W'(1) <<< (OUT_W - 1)) - IN_W'(1);
  localparam logic signed [IN_W-1:0] LO = -(IN_W'(1) <<< (OUT_W - 1));
  always_comb begin
    if (val_i > HI) begin
      sat_o = {1'b0, {(OUT_W-1){1'b1}}};
    end else if (val_i < LO) begin
      sat_o = {1'b1, {(OUT_W-1){1'b0}}};
    end else begin
      sat_o = val_i[OUT_W-1:0];
    end
  end
endmodule
`default_nettype wire

//--- logic/gpm_top.sv
// Purpose: power modes and measurement results of a battery monitor
// Assumes: bus pins and undervoltage comparator are asynchronous to REF_CLK_I
// Notes:   raw converter codes arrive as same-clock inputs, sampled on internal timers
`default_nettype none
module gpm_top
  import gpm_pkg::*;
#(
  parameter int unsigned SLEEP_CYC = SLEEP_DELAY_CYC,
  parameter int unsigned VT_CYC    = VT_PERIOD_CYC,
  parameter int unsigned CONV_CYC  = CONV_PERIOD_CYC,
  parameter int unsigned SMP_CYC   = SAMPLE_CYC
) (
  // clock and reset
  input  wire logic                    REF_CLK_I,
  input  wire logic                    SRST_I,
  // bus lines, monitored only
  input  wire logic                    SDA_I,
  input  wire logic                    SCL_I,
  // configuration
  input  wire logic                    SLEEP_ON_BUS_LOW_ENABLE_I,
  input  wire logic                    SLEEP_ON_UNDERVOLTAGE_ENABLE_I,
  input  wire gpm_trim_t               TRIM_I,
  // analog front end
  input  wire logic                    CELL_BELOW_SLEEP_THRESHOLD_I,
  input  wire logic signed [RES_W-1:0] CELL_VOLTAGE_RAW_I,
  input  wire logic signed [RES_W-1:0] TEMPERATURE_RAW_I,
  input  wire logic signed [RES_W-1:0] SENSE_RESISTOR_RAW_I,
  input  wire logic signed [RES_W-1:0] OFFSET_RAW_I,
  // status
  output logic                         ACTIVE_O,
  output logic                         START_READY_O,
  output logic                         SAMPLE_STROBE_O,
  output logic                         OFFSET_SLOT_O,
  output gpm_results_t                 RESULTS_O
);
  localparam int unsigned SW  = $clog2(SLEEP_CYC + 1);
  localparam int unsigned VW  = $clog2(VT_CYC + 1);
  localparam int unsigned CW  = $clog2(CONV_CYC + 1);
  localparam int unsigned MW  = $clog2(SMP_CYC + 1);
  localparam int unsigned OW  = $clog2(OFFSET_SLOT_EVERY);
  localparam int unsigned AW  = RES_W + AVG_LOG2;
  localparam int unsigned PW  = 48;

  typedef struct packed {
    logic [1:0]              sda_sync;
    logic [1:0]              scl_sync;
    logic [1:0]              uv_sync;
    logic                    sda_q;
    logic                    scl_q;
    gpm_mode_t               mode;
    logic                    bus_high_at_entry;
    logic [SW-1:0]           idle_cnt;
    logic [VW-1:0]           vt_cnt;
    logic [CW-1:0]           conv_cnt;
    logic [MW-1:0]           smp_cnt;
    logic [OW-1:0]           conv_idx;
    logic [AVG_LOG2-1:0]     avg_idx;
    logic [AVG_LOG2-1:0]     avg_fill;
    logic signed [RES_W-1:0] offset;
    logic [TEMPCO_W+RES_W-1:0] comp;
    logic signed [RES_W-1:0] temp_band;
    logic                    smp_pulse;
    logic                    slot_flag;
    logic                    act;
    logic                    start_ready;
    gpm_results_t            res;
  } gpm_state_t;

  gpm_state_t              s;
  gpm_state_t              next_s;
  logic signed [RES_W-1:0] hist [AVG_DEPTH];
  logic signed [PW-1:0]    cur_wide;
  logic signed [RES_W-1:0] cur_sat;
  logic signed [RES_W-1:0] volt_sat;
  logic signed [AW-1:0]    avg_sum;
  logic signed [RES_W-1:0] avg_sat;
  logic                    sda;
  logic                    scl;
  logic                    bus_edge;
  logic                    bus_low;
  logic                    bus_high;
  logic                    conv_done;
  logic                    avg_write;
  logic                    quiet_done;
  logic signed [RES_W-1:0] hist_in;

  assign sda      = s.sda_sync[1];
  assign scl      = s.scl_sync[1];
  assign bus_edge = (sda != s.sda_q) || (scl != s.scl_q);
  assign bus_low  = !sda && !scl;
  assign bus_high = sda && scl;
  assign conv_done = (s.mode == GPM_ACTIVE) && (s.conv_cnt == CW'(CONV_CYC - 1));
  // last sample of a batch of eight completes the 28s window
  assign avg_write = conv_done && (s.avg_fill == AVG_LOG2'(AVG_DEPTH - 1));
  // a saturated count left over from the previous bus state must not count on an edge
  assign quiet_done = (s.idle_cnt == SW'(SLEEP_CYC)) && !bus_edge;
  assign hist_in    = (s.conv_idx == OW'(OFFSET_SLOT_EVERY - 1)) ? s.res.current : cur_sat;

  // gain is unsigned Q1.10 from the reprogrammable copy; factory copy stays unread
  always_comb begin
    logic signed [PW-1:0] raw;
    logic signed [PW-1:0] gained;
    raw      = PW'(SENSE_RESISTOR_RAW_I) - PW'(s.offset);
    gained   = (raw * $signed({1'b0, TRIM_I.gain_trim})) >>> GAIN_FRAC;
    // tempco scale: comp holds tempco times half-degree steps, 2^-16 per unit
    cur_wide = gained + ((gained * $signed({1'b0, s.comp})) >>> TEMPCO_SHIFT);
  end

  gpm_sat #(.IN_W(PW), .OUT_W(RES_W)) u_sat_cur (
    .val_i (cur_wide),
    .sat_o (cur_sat)
  );

  gpm_sat #(.IN_W(PW), .OUT_W(RES_W)) u_sat_volt (
    .val_i (PW'(CELL_VOLTAGE_RAW_I)),
    .sat_o (volt_sat)
  );

  always_comb begin
    logic signed [AW-1:0] acc;
    acc = '0;
    for (int i = 0; i < AVG_DEPTH; i++) begin
      // sample stored this cycle joins the sum, so the window ends on it
      acc = acc + AW'((conv_done && AVG_LOG2'(i) == s.avg_idx) ? hist_in : hist[i]);
    end
    avg_sum = acc;
  end

  gpm_sat #(.IN_W(AW), .OUT_W(RES_W)) u_sat_avg (
    .val_i (avg_sum >>> AVG_LOG2),
    .sat_o (avg_sat)
  );

  always_comb begin
    logic signed [RES_W-1:0] band;
    band            = s.res.temperature >>> TEMP_HALF_SHIFT;
    next_s          = s;
    next_s.sda_sync = {s.sda_sync[0], SDA_I};
    next_s.scl_sync = {s.scl_sync[0], SCL_I};
    next_s.uv_sync  = {s.uv_sync[0], CELL_BELOW_SLEEP_THRESHOLD_I};
    next_s.sda_q    = sda;
    next_s.scl_q    = scl;
    next_s.smp_pulse = 1'b0;
    // steady-bus timer
    if (bus_edge || !(bus_low || bus_high)) begin
      next_s.idle_cnt = '0;
    end else if (s.idle_cnt != SW'(SLEEP_CYC)) begin
      next_s.idle_cnt = s.idle_cnt + SW'(1);
    end

    unique case (s.mode)
      GPM_ACTIVE: begin
        if (SLEEP_ON_BUS_LOW_ENABLE_I && bus_low && quiet_done) begin
          next_s.mode = GPM_SLEEP_BUS;
        end else if (SLEEP_ON_UNDERVOLTAGE_ENABLE_I && s.uv_sync[1] && quiet_done) begin
          next_s.mode              = GPM_SLEEP_UV;
          next_s.bus_high_at_entry = bus_high;
        end
      end
      GPM_SLEEP_BUS: begin
        // pulled-down lines of an undriven charger never wake it
        if (sda || scl) begin
          next_s.mode = GPM_ACTIVE;
        end
      end
      GPM_SLEEP_UV: begin
        if (bus_edge) begin
          next_s.mode = GPM_ACTIVE;
        end
      end
      default: next_s.mode = GPM_ACTIVE;
    endcase

    // timers freeze while asleep so results hold their last values
    if (s.mode == GPM_ACTIVE) begin
      next_s.vt_cnt = (s.vt_cnt == VW'(VT_CYC - 1)) ? '0 : s.vt_cnt + VW'(1);
      if (s.vt_cnt == VW'(VT_CYC - 1)) begin
        next_s.res.voltage     = volt_sat;
        next_s.res.temperature = TEMPERATURE_RAW_I;
      end
      next_s.smp_cnt = (s.smp_cnt == MW'(SMP_CYC - 1)) ? '0 : s.smp_cnt + MW'(1);
      next_s.smp_pulse = (s.smp_cnt == MW'(SMP_CYC - 1));
      next_s.conv_cnt = conv_done ? '0 : s.conv_cnt + CW'(1);
      if (conv_done) begin
        next_s.conv_idx = s.conv_idx + OW'(1);
        if (s.conv_idx == OW'(OFFSET_SLOT_EVERY - 1)) begin
          // offset slot: hold previous current, refresh correction
          next_s.offset = OFFSET_RAW_I;
        end else begin
          next_s.res.current = cur_sat;
        end
        next_s.avg_idx  = s.avg_idx + AVG_LOG2'(1);
        next_s.avg_fill = s.avg_fill + AVG_LOG2'(1);
      end
      if (avg_write) begin
        next_s.res.avg_current = avg_sat;
      end
      if (band != s.temp_band) begin
        next_s.temp_band = band;
        next_s.comp = band[RES_W-1] ? '0 :
                      (TEMPCO_W+RES_W)'(TRIM_I.tempco * band[RES_W-2:0]);
      end
    end
    next_s.slot_flag = (s.conv_idx == OW'(OFFSET_SLOT_EVERY - 1)) && (s.mode == GPM_ACTIVE);
    // mode flags registered so the status pins come straight from flops
    next_s.act         = (next_s.mode == GPM_ACTIVE);
    next_s.start_ready = (next_s.mode == GPM_ACTIVE) ||
                         (next_s.mode == GPM_SLEEP_UV && next_s.bus_high_at_entry);
  end

  // history ring for the average; offset slot stores the repeated value
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      for (int i = 0; i < AVG_DEPTH; i++) begin
        hist[i] <= RES_RST;
      end
    end else if (conv_done) begin
      hist[s.avg_idx] <= hist_in;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      s      <= '0;
      s.mode <= GPM_ACTIVE;
      s.act  <= 1'b1;
      s.start_ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign ACTIVE_O        = s.act;
  assign START_READY_O   = s.start_ready;
  assign SAMPLE_STROBE_O = s.smp_pulse;
  assign OFFSET_SLOT_O   = s.slot_flag;
  assign RESULTS_O       = s.res;
endmodule
`default_nettype wire

//--- tb/gpm_host.sv
// Purpose: host two-wire master driving bus levels
// Assumes: 320 ns link clock, still outside frames
// Notes:   floated lines read low through the pull-downs
`default_nettype none
module gpm_host (
  // bus lines
  output var logic sda_o,
  output var logic scl_o
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic float_bus();
    sda_o = 1'b0;
    scl_o = 1'b0;
  endtask
  task automatic release_bus();
    sda_o = 1'b1;
    scl_o = 1'b1;
  endtask
  // bus released first, then start, stop, start
  task automatic start_stop_start();
    release_bus();
    #320 sda_o = 1'b0;
    #160 scl_o = 1'b0;
    #160 scl_o = 1'b1;
    #160 sda_o = 1'b1;
    #320 sda_o = 1'b0;
    #160 scl_o = 1'b0;
    #160 scl_o = 1'b1;
  endtask
  initial release_bus();
endmodule
`default_nettype wire

//--- tb/gpm_top_sva.sv
// Purpose: port checks of the gauge power block
// Assumes: shortened timer parameters
// Notes:   bound onto gpm_top
`default_nettype none
module gpm_top_sva
  import gpm_pkg::*;
#(
  parameter int unsigned SLEEP_CYC = 50
) (
  // clock and reset
  input wire logic         REF_CLK_I,
  input wire logic         SRST_I,
  // watched ports
  input wire logic         SDA_I,
  input wire logic         SCL_I,
  input wire logic         ACTIVE_O,
  input wire logic         START_READY_O,
  input wire logic         SAMPLE_STROBE_O,
  input wire logic         OFFSET_SLOT_O,
  input wire gpm_results_t RESULTS_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);
  // pin quiet time; slack of 8 covers the synchronizer lag
  int unsigned quiet;
  always_ff @(posedge REF_CLK_I) quiet <= (SRST_I || $changed(SDA_I) || $changed(SCL_I)) ? 0 : quiet + 1;
  sequence bus_high_s; SDA_I || SCL_I; endsequence
  sequence woke_s; ##[1:6] ACTIVE_O; endsequence
  reset_mode_a: assert property (disable iff (1'b0) SRST_I |=> ACTIVE_O && RESULTS_O == '0)
    else $error("mode or results wrong after reset");
  sleep_freeze_a: assert property (!ACTIVE_O ##1 !ACTIVE_O |-> $stable(RESULTS_O))
    else $error("results moved while asleep");
  change_active_a: assert property (!$stable(RESULTS_O) |-> $past(ACTIVE_O))
    else $error("results changed outside active mode");
  entry_quiet_a: assert property ($fell(ACTIVE_O) |-> $past(quiet, 4) >= SLEEP_CYC - 8)
    else $error("sleep entered without a quiet bus");
  bus_wake_a: assert property (!ACTIVE_O && !START_READY_O ##0 bus_high_s |-> woke_s)
    else $error("no wake on a high bus line");
  uv_wake_a: assert property (!ACTIVE_O && START_READY_O && ($changed(SDA_I) || $changed(SCL_I)) |-> woke_s)
    else $error("no wake on a bus edge");
  ready_a: assert property (ACTIVE_O |-> START_READY_O)
    else $error("start not ready while active");
  strobe_idle_a: assert property (!ACTIVE_O ##1 !ACTIVE_O |-> !SAMPLE_STROBE_O)
    else $error("sampling while asleep");
  strobe_pulse_a: assert property (SAMPLE_STROBE_O |=> !SAMPLE_STROBE_O)
    else $error("sample strobe longer than one cycle");
  slot_hold_a: assert property ($fell(OFFSET_SLOT_O) |-> $stable(RESULTS_O.current))
    else $error("current changed after offset slot");
endmodule
bind gpm_top gpm_top_sva #(.SLEEP_CYC(SLEEP_CYC)) gpm_top_sva_inst (.REF_CLK_I, .SRST_I, .SDA_I, .SCL_I,
  .ACTIVE_O, .START_READY_O, .SAMPLE_STROBE_O, .OFFSET_SLOT_O, .RESULTS_O);
`default_nettype wire

//--- tb/test_gpm_top.sv
// Purpose: directed bench of the gauge power block
// Assumes: shortened timers
// Notes:   offset slot needs about 41k cycles
`default_nettype none
module test_gpm_top;
  timeunit 1ns;
  timeprecision 100ps;
  import gpm_pkg::*;
  localparam int unsigned SC = 50;
  localparam int unsigned CC = 40;
  logic                    clk = 0, rst = 1, bl_en = 0, uv_en = 0, below = 0;
  gpm_trim_t               trim = '{11'h400, 11'h000, 8'h00};
  logic signed [RES_W-1:0] volt = '0, temp = '0, sense_resistor_input = '0, ofs = '0;
  wire logic               sda, scl, act, rdy, slot, stb;
  gpm_results_t            res;
  int                      bad_count = 0, compares = 0;
  int                      stb_cnt = 0, n0 = 0;
  initial forever #20 clk = ~clk;
  always @(posedge clk)
    if (stb === 1'b1)
      stb_cnt <= stb_cnt + 1;
  gpm_host gpm_host_inst (.sda_o(sda), .scl_o(scl));
  gpm_top #(.SLEEP_CYC(SC), .VT_CYC(20), .CONV_CYC(CC), .SMP_CYC(4)) gpm_top_inst (.REF_CLK_I(clk),
    .SRST_I(rst), .SDA_I(sda), .SCL_I(scl), .SLEEP_ON_BUS_LOW_ENABLE_I(bl_en),
    .SLEEP_ON_UNDERVOLTAGE_ENABLE_I(uv_en), .TRIM_I(trim), .CELL_BELOW_SLEEP_THRESHOLD_I(below),
    .CELL_VOLTAGE_RAW_I(volt), .TEMPERATURE_RAW_I(temp), .SENSE_RESISTOR_RAW_I(sense_resistor_input), .OFFSET_RAW_I(ofs),
    .ACTIVE_O(act), .START_READY_O(rdy), .SAMPLE_STROBE_O(stb), .OFFSET_SLOT_O(slot), .RESULTS_O(res));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic check_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait on the mode output
  task automatic wait_act(input logic e, input int n);
    for (int i = 0; i < n && act !== e; i++) tick(1);
    check_bit("active", e, act);
    if (act !== e) results();
  endtask
  initial begin
    tick(6);
    rst = 0;
    check_bit("active", 1'b1, act);
    check_word("voltage", 16'h0000, res.voltage);
    n0 = stb_cnt;
    volt = 16'h0123;
    temp = 16'h00C8;
    sense_resistor_input = 16'h0400;
    tick(CC + 2);
    check_word("voltage", 16'h0123, res.voltage);
    check_word("temperature", 16'h00C8, res.temperature);
    check_word("current", 16'h0400, res.current);
    check_word("strobes", 16'h000A, 16'(stb_cnt - n0));
    tick(16 * CC);
    check_word("avg current", 16'h0400, res.avg_current);
    trim.gain_trim = 11'h7FF;
    sense_resistor_input = 16'h7000;
    tick(CC + 1);
    check_word("current", 16'h7FFF, res.current);
    sense_resistor_input = 16'h9000;
    tick(16 * CC);
    check_word("current", 16'h8000, res.current);
    check_word("avg current", 16'h8000, res.avg_current);
    trim.gain_trim = 11'h400;
    sense_resistor_input = 16'h0400;
    trim.tempco = 8'hFF;
    tick(2 * CC);
    check_word("current", 16'h0400, res.current);
    temp = 16'h00CC;
    tick(2 * CC);
    check_word("current", 16'h04CB, res.current);
    trim.tempco = 8'h00;
    temp = 16'h00C8;
    tick(2 * CC);
    check_word("current", 16'h0400, res.current);
    ofs = 16'h0064;
    for (int i = 0; i < 45000 && slot !== 1'b1; i++) tick(1);
    check_bit("offset slot", 1'b1, slot);
    if (slot !== 1'b1) results();
    for (int i = 0; i < 2 * CC && slot !== 1'b0; i++) tick(1);
    check_bit("offset slot", 1'b0, slot);
    if (slot !== 1'b0) results();
    check_word("current", 16'h0400, res.current);
    tick(CC);
    check_word("current", 16'h039C, res.current);
    bl_en = 1;
    gpm_host_inst.float_bus();
    tick(SC - 10);
    check_bit("active", 1'b1, act);
    wait_act(1'b0, 40);
    tick(1);
    n0 = stb_cnt;
    tick(3 * CC);
    check_word("current", 16'h039C, res.current);
    check_word("strobes", 16'h0000, 16'(stb_cnt - n0));
    check_bit("start ready", 1'b0, rdy);
    gpm_host_inst.release_bus();
    wait_act(1'b1, 8);
    bl_en = 0;
    uv_en = 1;
    below = 1;
    wait_act(1'b0, SC + 20);
    check_bit("start ready", 1'b1, rdy);
    gpm_host_inst.start_stop_start();
    wait_act(1'b1, 8);
    results();
  end
endmodule
`default_nettype wire
